// ### rtl/abs_data_fetch.sv
`timescale 1ns/10ps
module abs_data_fetch
    import homing_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               sys_rst,
    input  wire logic               run_cmd,
    input  wire logic               abs_valid,
    input  wire logic [POS_W-1:0]   abs_position,
    output logic                    abs_data_request,
    output logic                    abs_loaded,
    output logic [POS_W-1:0]        abs_latched
);
    import homing_pkg::*;

    logic run_prev;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            run_prev <= 1'b0;
        end else begin
            run_prev <= run_cmd;
        end
    end

    // Request rises one clock after the run command and stays high while it is on.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            abs_data_request <= 1'b0;
        end else begin
            abs_data_request <= run_cmd; // [R06] [R07]
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            abs_loaded  <= 1'b0;
            abs_latched <= POS_RESET;
        end else if (run_cmd && !run_prev) begin
            abs_loaded <= 1'b0;
        end else if (abs_valid && abs_data_request) begin
            abs_loaded  <= 1'b1; // [R06]
            abs_latched <= abs_position;
        end
    end

    a_req_follows_run: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(run_cmd) |=> abs_data_request) // [R07]
        else $error("request did not rise with run command");

    a_req_low_idle: assert property (@(posedge clock) disable iff (sys_rst)
        !run_cmd |=> !abs_data_request) // [R06]
        else $error("request high without run command");

endmodule

// ### rtl/homing_pkg.sv
package homing_pkg;

    localparam logic [1:0] METHOD_POWER_ON = 2'h0;
    localparam logic [1:0] METHOD_REVERSE  = 2'h1;
    localparam logic [1:0] METHOD_ONE_DIR  = 2'h2;

    localparam logic [1:0] SPEED_ZERO = 2'h0;
    localparam logic [1:0] SPEED_HIGH = 2'h1;
    localparam logic [1:0] SPEED_LOW  = 2'h2;
    localparam logic [1:0] SPEED_OFFS = 2'h3;

    localparam int POS_W = 32;
    localparam logic [31:0] POS_RESET = 32'h0000_0000;

    // Slowest stop the axis may need after the driver is told to stop.
    localparam int STOP_TIME_MS     = 100;
    localparam int CLOCK_HZ         = 20_000_000;
    localparam int STOP_CYCLES      = STOP_TIME_MS * (CLOCK_HZ / 1000);
    // Width of the counter that waits for the stop.
    localparam int STOP_CNT_W       = 22;
    localparam logic [21:0] STOP_CNT_RESET = 22'h00_0000;

    typedef struct packed {
        logic [1:0] method;
        logic       z_dir_ccw;
        logic       init_dir_ccw;
        logic       limit_decel;
        logic       prox_nc;
    } home_cfg_t;

    typedef struct packed {
        logic cw_limit;
        logic ccw_limit;
        logic origin_prox;
        logic index_pulse;
        logic stopped;
    } axis_in_t;

    typedef struct packed {
        logic [1:0] speed;
        logic       dir_ccw;
        logic       hard_stop;
        logic       decel_stop;
    } motion_cmd_t;

endpackage

// ### rtl/origin_search_abs_encoder_ctrl.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// [R01] Homing starts in the configured initial direction, not the index direction.
// [R02] With proximity and both limits off, first move opposite the initial direction.
// [R03] On a limit, reverse only after the axis stops, hard or decelerated.
// [R04] Reverse mode with proximity: no index pulse ends the search with error.
// [R05] Power-on mode takes the present position as origin without moving; the code latches it in the first clock after reset, not on the command.
// [R06] Absolute data is requested by raising the request line, then received.
// [R07] The request line rises when the run command rises; the code raises it one clock after the run command.
// [R08] Servo lock reads absolute data as a tentative origin until homing.
// [R09] Absolute encoder with origin set gives position at power-up, no search.
// [R10] After index origin, a nonzero offset is travelled and becomes origin.
// [R11] Host issues no servo lock during encoder capacitor charging.
// [R12] One-direction mode flags error if a limit comes before proximity.
// [R13] Reverse mode reverses direction whenever a limit becomes active; the code flags an error instead on a limit in ST_LEAVE or ST_INDEX.
// [R14] Move at high speed, then low speed once proximity becomes active.
// [R15] After proximity clears, latch origin at first index and stop.
// [R16] Done and error flags stay set until the next homing command.
// [R17] Configuration is sampled when a search starts.
module origin_search_abs_encoder_ctrl
    import homing_pkg::*;
#(
    parameter int STOP_WAIT = STOP_CYCLES
)
(
    input  wire logic                   clock,
    input  wire logic                   sys_rst,
    input  wire homing_pkg::home_cfg_t  cfg,
    input  wire homing_pkg::axis_in_t   axis_in,
    input  wire logic                   home_start,
    input  wire logic                   servo_lock,
    input  wire logic                   abs_encoder,
    input  wire logic                   abs_origin_set,
    input  wire logic                   jog_origin_set,
    input  wire logic [31:0]            ref_offset,
    input  wire logic                   offset_done,
    input  wire logic [31:0]            feedback_pos,
    input  wire logic                   abs_valid,
    input  wire logic [31:0]            abs_position,
    output homing_pkg::motion_cmd_t     motion,
    output logic                        run_cmd,
    output logic                        abs_data_request,
    output logic                        home_done,
    output logic                        home_error,
    output logic                        origin_valid,
    output logic                        origin_tentative,
    output logic [31:0]                 origin_pos
);
    import homing_pkg::*;

    typedef enum logic [6:0] {
        ST_IDLE    = 7'b000_0001,
        ST_SEARCH  = 7'b000_0010,
        ST_STOP    = 7'b000_0100,
        ST_LEAVE   = 7'b000_1000,
        ST_INDEX   = 7'b001_0000,
        ST_OFFSET  = 7'b010_0000,
        ST_FAIL    = 7'b100_0000
    } state_t;

    state_t         state;
    home_cfg_t      cfg_s;
    logic           prox;
    logic           limit_hit;
    logic           seen_prox;
    logic           prox_left;
    logic [21:0]    stop_cnt;
    logic           abs_loaded;
    logic [31:0]    abs_latched;
    logic           abs_loaded_prev;
    logic           pwr_done;

    localparam logic [21:0] STOP_WAIT_N = 22'(STOP_WAIT);

    function automatic logic prox_level(input logic raw, input logic nc);
        return nc ? !raw : raw;
    endfunction

    assign prox      = prox_level(axis_in.origin_prox, cfg_s.prox_nc);
    assign limit_hit = motion.dir_ccw ? axis_in.ccw_limit : axis_in.cw_limit;

    ////////////////////////////////////////////////////////////////////////////
    abs_data_fetch u_fetch (
        .clock            (clock),
        .sys_rst          (sys_rst),
        .run_cmd          (run_cmd),
        .abs_valid        (abs_valid),
        .abs_position     (abs_position),
        .abs_data_request (abs_data_request),
        .abs_loaded       (abs_loaded),
        .abs_latched      (abs_latched)
    );

    // Run command follows servo lock; the host keeps lock off while charging.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            run_cmd <= 1'b0;
        end else begin
            run_cmd <= servo_lock; // [R11]
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_s <= '0;
        end else if (home_start && state == ST_IDLE) begin
            cfg_s <= cfg; // [R17]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state     <= ST_IDLE;
            motion    <= '0;
            seen_prox <= 1'b0;
            prox_left <= 1'b0;
            stop_cnt  <= STOP_CNT_RESET;
        end else begin
            case (state)
                ST_IDLE: begin
                    motion <= '0;
                    if (home_start && cfg.method != METHOD_POWER_ON) begin
                        seen_prox <= 1'b0;
                        prox_left <= 1'b0;
                        motion.speed <= SPEED_HIGH; // [R14]
                        if (!prox_level(axis_in.origin_prox, cfg.prox_nc)
                            && !axis_in.cw_limit && !axis_in.ccw_limit) begin
                            motion.dir_ccw <= !cfg.init_dir_ccw; // [R02]
                        end else begin
                            motion.dir_ccw <= cfg.init_dir_ccw; // [R01]
                        end
                        state <= ST_SEARCH;
                    end
                end
                ST_SEARCH: begin
                    if (prox) begin
                        seen_prox    <= 1'b1;
                        motion.speed <= SPEED_LOW; // [R14]
                        if (motion.dir_ccw == cfg_s.z_dir_ccw) begin
                            state <= ST_LEAVE;
                        end
                    end else if (limit_hit) begin
                        if (cfg_s.method == METHOD_ONE_DIR && !seen_prox) begin
                            state <= ST_FAIL; // [R12]
                        end else if (cfg_s.method == METHOD_REVERSE && prox_left) begin
                            state <= ST_FAIL; // [R04]
                        end else begin
                            motion.speed      <= SPEED_ZERO; // [R03]
                            motion.hard_stop  <= !cfg_s.limit_decel;
                            motion.decel_stop <= cfg_s.limit_decel;
                            stop_cnt          <= STOP_CNT_RESET;
                            state             <= ST_STOP;
                        end
                    end
                end
                ST_STOP: begin
                    if (stop_cnt < STOP_WAIT_N) begin
                        stop_cnt <= stop_cnt + 22'h00_0001;
                    end
                    if (axis_in.stopped && stop_cnt != STOP_CNT_RESET) begin
                        motion.hard_stop  <= 1'b0;
                        motion.decel_stop <= 1'b0;
                        motion.dir_ccw    <= !motion.dir_ccw; // [R13] [R03]
                        motion.speed      <= seen_prox ? SPEED_LOW : SPEED_HIGH;
                        state             <= ST_SEARCH;
                    end
                end
                ST_LEAVE: begin
                    if (!prox) begin
                        prox_left <= 1'b1;
                        state     <= ST_INDEX;
                    end else if (limit_hit) begin
                        state <= ST_FAIL;
                    end
                end
                ST_INDEX: begin
                    if (axis_in.index_pulse) begin
                        if (ref_offset != 32'h0000_0000) begin
                            motion.speed <= SPEED_OFFS; // [R10]
                            state        <= ST_OFFSET;
                        end else begin
                            motion.speed <= SPEED_ZERO; // [R15]
                            state        <= ST_IDLE;
                        end
                    end else if (limit_hit) begin
                        state <= ST_FAIL; // [R04]
                    end
                end
                ST_OFFSET: begin
                    if (offset_done) begin
                        motion.speed <= SPEED_ZERO; // [R10]
                        state        <= ST_IDLE;
                    end
                end
                default: begin
                    motion <= '0;
                    state  <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags and the origin register share one process so that
    // completion and the latched origin never disagree for a cycle.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            home_done        <= 1'b0;
            home_error       <= 1'b0;
            origin_valid     <= 1'b0;
            origin_tentative <= 1'b0;
            origin_pos       <= POS_RESET;
            abs_loaded_prev  <= 1'b0;
            pwr_done         <= 1'b0;
        end else begin
            abs_loaded_prev <= abs_loaded;
            if (!pwr_done) begin
                pwr_done <= 1'b1;
                if (!abs_encoder) begin
                    origin_pos   <= feedback_pos; // [R05]
                    origin_valid <= cfg.method == METHOD_POWER_ON;
                end
            end
            if (home_start && state == ST_IDLE) begin
                home_done  <= cfg.method == METHOD_POWER_ON; // [R16]
                home_error <= 1'b0;
                if (cfg.method == METHOD_POWER_ON) begin
                    origin_valid <= 1'b1; // [R05]
                end
            end else if (state == ST_FAIL) begin
                home_error <= 1'b1; // [R04] [R12]
            end else if (state == ST_INDEX && axis_in.index_pulse) begin
                origin_pos <= feedback_pos; // [R15]
                if (ref_offset == 32'h0000_0000) begin
                    home_done        <= 1'b1;
                    origin_valid     <= 1'b1;
                    origin_tentative <= 1'b0;
                end
            end else if (state == ST_OFFSET && offset_done) begin
                origin_pos       <= origin_pos + ref_offset; // [R10]
                home_done        <= 1'b1;
                origin_valid     <= 1'b1;
                origin_tentative <= 1'b0;
            end else if (jog_origin_set) begin
                origin_pos       <= feedback_pos; // [R08]
                origin_valid     <= 1'b1;
                origin_tentative <= 1'b0;
            end else if (abs_encoder && abs_loaded && !abs_loaded_prev) begin
                origin_pos <= abs_latched;
                if (abs_origin_set) begin
                    origin_valid <= 1'b1; // [R09]
                end else begin
                    origin_tentative <= 1'b1; // [R08]
                end
            end
        end
    end

    a_start_dir: assert property (@(posedge clock) disable iff (sys_rst)
        state == ST_IDLE && home_start && cfg.method != METHOD_POWER_ON
        && (axis_in.cw_limit || axis_in.ccw_limit)
        |=> motion.dir_ccw == $past(cfg.init_dir_ccw)) // [R01]
        else $error("search did not start in initial direction");

    a_start_flip: assert property (@(posedge clock) disable iff (sys_rst)
        state == ST_IDLE && home_start && cfg.method != METHOD_POWER_ON
        && !axis_in.cw_limit && !axis_in.ccw_limit
        && !prox_level(axis_in.origin_prox, cfg.prox_nc)
        |=> motion.dir_ccw != $past(cfg.init_dir_ccw)) // [R02]
        else $error("search did not start opposite to initial direction");

    sequence s_stopping;
        state == ST_STOP && !axis_in.stopped;
    endsequence

    a_rev_after_stop: assert property (@(posedge clock) disable iff (sys_rst)
        s_stopping |=> $stable(motion.dir_ccw)) // [R03]
        else $error("direction changed before axis stopped");

    a_stop_kind: assert property (@(posedge clock) disable iff (sys_rst)
        state == ST_STOP |-> motion.hard_stop != motion.decel_stop) // [R03]
        else $error("stop kind not exclusive");

    a_onedir_err: assert property (@(posedge clock) disable iff (sys_rst)
        state == ST_SEARCH && cfg_s.method == METHOD_ONE_DIR && !seen_prox
        && !prox && limit_hit |=> ##1 home_error) // [R12]
        else $error("limit before proximity gave no error");

    a_power_on: assert property (@(posedge clock) disable iff (sys_rst)
        state == ST_IDLE && home_start && cfg.method == METHOD_POWER_ON
        |=> state == ST_IDLE && home_done && motion.speed == SPEED_ZERO) // [R05]
        else $error("power-on origin moved or did not complete");

    a_index_stop: assert property (@(posedge clock) disable iff (sys_rst)
        state == ST_INDEX && axis_in.index_pulse && ref_offset == 32'h0000_0000
        |=> motion.speed == SPEED_ZERO && home_done
        && origin_pos == $past(feedback_pos)) // [R15]
        else $error("index did not stop and latch origin");

    a_low_speed: assert property (@(posedge clock) disable iff (sys_rst)
        state == ST_SEARCH && prox && !limit_hit |=> motion.speed == SPEED_LOW) // [R14]
        else $error("proximity did not select low speed");

    a_flags_hold: assert property (@(posedge clock) disable iff (sys_rst)
        home_done && !(home_start && state == ST_IDLE) |=> home_done) // [R16]
        else $error("done flag dropped without new command");

endmodule

// ### test/origin_search_abs_encoder_ctrl_test.sv
`timescale 1ns/10ps
module origin_search_abs_encoder_ctrl_test;
    import homing_pkg::*;
    // Wait with servo lock on between the tentative origin check and the jog origin set.
    localparam int CHARGE = 40;
    logic         clock          = 1'b0;
    logic         sys_rst        = 1'b1;
    home_cfg_t    cfg            = '0;
    logic         home_start     = 1'b0;
    logic         servo_lock     = 1'b0;
    logic         abs_encoder    = 1'b0;
    logic         abs_origin_set = 1'b0;
    logic         jog_origin_set = 1'b0;
    logic [31:0]  ref_offset     = 32'h0000_0000;
    logic         offset_done    = 1'b0;
    logic         index_en       = 1'b1;
    logic         load           = 1'b0;
    logic [31:0]  load_pos       = 32'h0000_0000;
    logic [31:0]  abs_value      = 32'h0000_0000;
    logic         mon_en         = 1'b0;
    logic         prev_stop_cmd  = 1'b0;
    logic         prev_stopped   = 1'b0;
    logic         exp_decel      = 1'b0;
    int           fail_count     = 0;
    int           n_tests        = 0;
    axis_in_t     axis_in;
    motion_cmd_t  motion;
    logic [31:0]  feedback_pos, abs_position, origin_pos, o;
    logic         abs_valid, run_cmd, abs_data_request, init_dir;
    logic         home_done, home_error, origin_valid, origin_tentative;

    always #25 clock = ~clock;

    origin_search_abs_encoder_ctrl #(.STOP_WAIT(4)) u_dut (
        .clock(clock), .sys_rst(sys_rst), .cfg(cfg), .axis_in(axis_in),
        .home_start(home_start), .servo_lock(servo_lock), .abs_encoder(abs_encoder),
        .abs_origin_set(abs_origin_set), .jog_origin_set(jog_origin_set),
        .ref_offset(ref_offset), .offset_done(offset_done), .feedback_pos(feedback_pos),
        .abs_valid(abs_valid), .abs_position(abs_position), .motion(motion),
        .run_cmd(run_cmd), .abs_data_request(abs_data_request), .home_done(home_done),
        .home_error(home_error), .origin_valid(origin_valid),
        .origin_tentative(origin_tentative), .origin_pos(origin_pos));

    servo_axis_model u_axis (
        .clock(clock), .prox_nc(cfg.prox_nc), .index_en(index_en), .load(load),
        .load_pos(load_pos), .abs_value(abs_value), .motion(motion),
        .abs_data_request(abs_data_request), .axis_in(axis_in),
        .feedback_pos(feedback_pos), .abs_valid(abs_valid), .abs_position(abs_position));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask

    // A clear path (no proximity, no limit) starts against the initial direction.
    function automatic logic exp_start_dir(input logic init_ccw, input logic clear_path);
        return clear_path ? !init_ccw : init_ccw;
    endfunction

    task automatic wait_end(input int lim);
        for (int k = 0; k < lim && home_done !== 1'b1 && home_error !== 1'b1; k++) tick(1);
    endtask

    task automatic wait_move();
        for (int k = 0; k < 4 && motion.speed === SPEED_ZERO; k++) tick(1);
    endtask

    task automatic start(input logic [1:0] m, input int at);
        cfg.method = m;
        exp_decel = cfg.limit_decel;
        load = 1'b1;
        load_pos = 32'(at);
        tick(1);
        load = 1'b0;
        home_start = 1'b1;
        tick(1);
        home_start = 1'b0;
    endtask

    // A good search ends stopped on an index mark with no error.
    task automatic search_ok();
        chk_bit(home_done, 1'b1);
        chk_bit(home_error, 1'b0);
        chk_word({28'h0, origin_pos[3:0]}, 32'h0000_0000);
        chk_word(32'(motion.speed), 32'(SPEED_ZERO));
    endtask

    task automatic print_verdict();
        $display("Comparisons: %0d, mismatches: %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watches every stop: its kind follows the setting and motion resumes only once stopped.
    always @(posedge clock) begin
        #1;
        if (mon_en) begin
            if (motion.hard_stop || motion.decel_stop)
                chk_bit(motion.decel_stop, exp_decel);
            if (prev_stop_cmd && motion.speed != SPEED_ZERO)
                chk_bit(prev_stopped, 1'b1);
        end
        prev_stop_cmd = motion.hard_stop || motion.decel_stop;
        prev_stopped = axis_in.stopped;
    end

    initial begin
        #4_500_000;
        fail_count++;
        print_verdict();
    end

    initial begin
        o = $urandom(23);
        tick(6);
        chk_word(32'({motion, run_cmd, abs_data_request, home_done, home_error}), 32'h0);
        tick(6);
        sys_rst = 1'b0;
        tick(2);
        chk_bit(origin_valid, 1'b1);
        chk_word(origin_pos, feedback_pos);
        mon_en = 1'b1;
        start(METHOD_POWER_ON, 37);
        wait_end(4);
        chk_bit(home_done, 1'b1);
        chk_word(32'(motion.speed), 32'(SPEED_ZERO));
        chk_word(origin_pos, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            cfg.z_dir_ccw = 1'($urandom);
            cfg.init_dir_ccw = 1'($urandom);
            init_dir = cfg.init_dir_ccw;
            cfg.limit_decel = 1'($urandom);
            cfg.prox_nc = 1'($urandom);
            start(METHOD_REVERSE, int'($urandom_range(360)) - 300);
            cfg.init_dir_ccw = ~init_dir;
            cfg.limit_decel = ~cfg.limit_decel;
            wait_move();
            chk_word(32'(motion.speed), 32'(SPEED_HIGH));
            chk_bit(motion.dir_ccw, exp_start_dir(init_dir, 1'b1));
            wait_end(6000);
            search_ok();
        end
        cfg.prox_nc = 1'b0;
        init_dir = cfg.init_dir_ccw;
        start(METHOD_REVERSE, 130);
        wait_move();
        chk_bit(motion.dir_ccw, exp_start_dir(init_dir, 1'b0));
        wait_end(6000);
        search_ok();
        index_en = 1'b0;
        start(METHOD_REVERSE, -200);
        wait_end(6000);
        chk_bit(home_error, 1'b1);
        chk_bit(home_done, 1'b0);
        index_en = 1'b1;
        cfg.z_dir_ccw = 1'b0;
        cfg.init_dir_ccw = 1'b0;
        start(METHOD_ONE_DIR, 400);
        wait_end(2000);
        chk_bit(home_error, 1'b1);
        tick(20);
        chk_bit(home_error, 1'b1);
        ref_offset = 32'($urandom_range(255)) + 32'h0000_0001;
        start(METHOD_REVERSE, -100);
        chk_bit(home_error, 1'b0);
        for (int k = 0; k < 6000 && motion.speed !== SPEED_OFFS; k++) tick(1);
        o = origin_pos;
        chk_word({28'h0, o[3:0]}, 32'h0000_0000);
        tick(10);
        offset_done = 1'b1;
        tick(1);
        offset_done = 1'b0;
        tick(2);
        chk_word(origin_pos, o + ref_offset);
        wait_end(5);
        chk_bit(home_done, 1'b1);
        abs_encoder = 1'b1;
        abs_value = $urandom;
        servo_lock = 1'b1;
        for (int k = 0; k < 4 && run_cmd !== 1'b1; k++) tick(1);
        chk_bit(run_cmd, 1'b1);
        chk_bit(abs_data_request, 1'b0);
        tick(1);
        chk_bit(abs_data_request, 1'b1);
        tick(12);
        chk_word(origin_pos, abs_value);
        chk_bit(origin_tentative, 1'b1);
        tick(CHARGE);
        jog_origin_set = 1'b1;
        tick(1);
        jog_origin_set = 1'b0;
        tick(2);
        chk_bit(origin_tentative, 1'b0);
        chk_word(origin_pos, feedback_pos);
        servo_lock = 1'b0;
        tick(4);
        abs_origin_set = 1'b1;
        abs_value = $urandom;
        servo_lock = 1'b1;
        tick(16);
        chk_bit(origin_valid, 1'b1);
        chk_word(origin_pos, abs_value);
        print_verdict();
    end
endmodule

// ### test/servo_axis_model.sv
`timescale 1ns/10ps
module servo_axis_model
    import homing_pkg::*;
(
    input  wire logic                    clock,
    input  wire logic                    prox_nc,
    input  wire logic                    index_en,
    input  wire logic                    load,
    input  wire logic [31:0]             load_pos,
    input  wire logic [31:0]             abs_value,
    input  wire homing_pkg::motion_cmd_t motion,
    input  wire logic                    abs_data_request,
    output homing_pkg::axis_in_t         axis_in,
    output logic [31:0]                  feedback_pos,
    output logic                         abs_valid,
    output logic [31:0]                  abs_position
);
    // Travel ends and proximity dog of the simulated axis; index every 16 counts.
    localparam int LIM     = 400;
    localparam int PROX_LO = 100;
    localparam int PROX_HI = 160;

    int pos     = 0;
    int idle    = 0;
    int req_age = 0;
    int step;
    int nxt;

    assign step = (motion.speed == SPEED_HIGH) ? 4 : ((motion.speed == SPEED_ZERO) ? 0 : 1);
    assign nxt  = motion.dir_ccw ? pos - step : pos + step;

    always @(posedge clock) begin
        idle <= (motion.speed == SPEED_ZERO) ? idle + 1 : 0;
        req_age <= abs_data_request ? req_age + 1 : 0;
        if (load) begin
            pos <= int'(load_pos);
        end else begin
            pos <= (nxt > LIM) ? LIM : ((nxt < -LIM) ? -LIM : nxt);
        end
    end

    // A decelerated stop settles later than a counter-pulse stop, so reversing early shows.
    assign axis_in.stopped     = idle >= (motion.decel_stop ? 4 : 1);
    assign axis_in.cw_limit    = pos >= LIM;
    assign axis_in.ccw_limit   = pos <= -LIM;
    assign axis_in.origin_prox = prox_nc ^ (pos >= PROX_LO && pos <= PROX_HI);
    assign axis_in.index_pulse = index_en && (feedback_pos[3:0] == 4'h0);
    assign feedback_pos        = 32'(pos);
    assign abs_valid           = req_age == 5;
    // Outside the valid cycle the data lines carry garbage, never the last word.
    assign abs_position        = abs_valid ? abs_value : ~abs_value;
endmodule
